/* File: design/stack_arith_pkg.sv */
// constants and types for the top-of-stack arithmetic datapath
// assumes a single 100 MHz clock and word-wide memory with one-cycle read
// Functional notes
// - drop top: decrement top pointer only
// - memory push: read, store above top, increment
// - add two tops, leave sum on top
// - multiply two tops, leave product on top
// - subtract: next-to-top minus top, one result
// - negate top by two's complement, depth unchanged
// - up to four top elements held internally
// - fetch from memory until operands cached (two, or one for negate and drop)
// - only memory push carries relative address
// - two packed operations run from one word
// - frame pointer oldest, top pointer current top
// - divide, keep quotient, drop remainder
// - push zero above top, increment pointer
package stack_arith_pkg;
  localparam int WORD_W = 16;
  localparam int CACHE_DEPTH = 4;
  localparam int CNT_W = 3;
  localparam int OP_W = 3;
  localparam int ADDR_W = 16;
  localparam int REL_W = 8;
  localparam logic [CNT_W-1:0] MIN_OPERANDS = 3'h2;
  localparam logic [CNT_W-1:0] ONE_CNT = 3'h1;
  localparam logic [ADDR_W-1:0] PTR_STEP = 16'h0001;
  localparam logic [WORD_W-1:0] ZERO_WORD = 16'h0000;
  localparam logic [ADDR_W-1:0] PTR_RESET = 16'h0000;
  // stack operation codes (one slot of a packed word)
  typedef enum logic [2:0] {
    NOP_OP = 3'b000,
    drop_top_op = 3'b001,
    PUSH_MEM_OP = 3'b010,
    ADD_OP = 3'b011,
    product_op = 3'b100,
    SUB_OP = 3'b101,
    NEG_OP = 3'b110,
    DIV_DROP_OP = 3'b111
  } stack_op_e;
  // packed word field positions: second op, first op, relative address
  localparam int FIRST_OP_LSB = 8;
  localparam int SECOND_OP_LSB = 11;
  localparam int REL_LSB = 0;
  localparam int PUSH_ZERO_LSB = 14;
endpackage

/* File: design/stack_alu.sv */
// combinational arithmetic core for two stack operands
// assumes operands are already cached; result truncated to one word
`timescale 1ns/10ps
`default_nettype none
module stack_alu
  import stack_arith_pkg::*;
(
  // operation and operands
  input wire stack_op_e op_in,
  input wire logic [WORD_W-1:0] next_in,
  input wire logic [WORD_W-1:0] top_in,
  // result
  output logic [WORD_W-1:0] result_out
);
  logic [2*WORD_W-1:0] prod; // full product before truncation

  // arithmetic per operation, 16-bit wrap
  always_comb begin
    prod = next_in * top_in;
    result_out = top_in;
    case (op_in)
      ADD_OP: result_out = next_in + top_in;
      product_op: result_out = prod[WORD_W-1:0];
      SUB_OP: result_out = next_in - top_in;
      NEG_OP: result_out = ZERO_WORD - top_in;
      DIV_DROP_OP: begin
        // quotient only; divide by zero yields zero
        if (top_in == ZERO_WORD) begin
          result_out = ZERO_WORD;
        end else begin
          result_out = WORD_W'($signed(next_in) / $signed(top_in));
        end
      end
      default: result_out = top_in;
    endcase
  end
endmodule // stack_alu
`default_nettype wire

/* File: design/stack_arithmetic_unit.sv */
// top-of-stack execution datapath with a four-entry register cache
// assumes memory answers a read in the cycle after mem_rd_out
`timescale 1ns/10ps
`default_nettype none
module stack_arithmetic_unit
  import stack_arith_pkg::*;
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // instruction word and handshake
  input wire logic instr_valid_in,
  input wire logic [WORD_W-1:0] instr_in,
  output logic instr_ready_out,
  // frame pointer load
  input wire logic frame_load_in,
  input wire logic [ADDR_W-1:0] frame_in,
  // memory port
  output logic mem_rd_out,
  output logic mem_wr_out,
  output logic [ADDR_W-1:0] mem_addr_out,
  output logic [WORD_W-1:0] mem_wdata_out,
  input wire logic [WORD_W-1:0] mem_rdata_in,
  // visible state
  output logic [ADDR_W-1:0] top_ptr_out,
  output logic [ADDR_W-1:0] frame_ptr_out,
  output logic [CNT_W-1:0] cached_count_out,
  output logic [WORD_W-1:0] top_word_out
);
  typedef enum logic [2:0] {
    IDLE_ST = 3'b000,
    DECODE_ST = 3'b001,
    FILL_ST = 3'b010,
    FILL_WAIT_ST = 3'b011,
    SPILL_ST = 3'b100,
    PUSH_RD_ST = 3'b101,
    PUSH_WAIT_ST = 3'b110,
    EXEC_ST = 3'b111
  } state_e;

  state_e state_reg, state_next; // sequencer state
  logic [WORD_W-1:0] cache_reg [CACHE_DEPTH]; // index 0 is top
  logic [WORD_W-1:0] cache_next [CACHE_DEPTH];
  logic [CNT_W-1:0] cached_count_reg, cached_count_next; // cached elements
  logic [ADDR_W-1:0] top_ptr_reg, top_ptr_next; // address of top
  logic [ADDR_W-1:0] frame_ptr_reg, frame_ptr_next; // oldest of group
  logic [WORD_W-1:0] instr_reg, instr_next; // held packed word
  logic slot_reg, slot_next; // 0 first op, 1 second op
  logic rd_reg, rd_next;
  logic wr_reg, wr_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [WORD_W-1:0] wdata_reg, wdata_next;
  logic ready_reg, ready_next;
  stack_op_e cur_op; // operation of current slot
  logic [WORD_W-1:0] alu_result;
  logic [CNT_W-1:0] need_cnt; // operands required internally
  logic pushes; // op adds an element
  logic [ADDR_W-1:0] deep_addr; // memory home of deepest cached word

  // pick the slot's operation from the packed word
  always_comb begin
    if (slot_reg) begin
      cur_op = stack_op_e'(instr_reg[SECOND_OP_LSB +: OP_W]);
    end else begin
      cur_op = stack_op_e'(instr_reg[FIRST_OP_LSB +: OP_W]);
    end
  end

  // operand demand per operation
  always_comb begin
    pushes = 1'b0;
    case (cur_op)
      ADD_OP, product_op, SUB_OP, DIV_DROP_OP: need_cnt = MIN_OPERANDS;
      NEG_OP, drop_top_op: need_cnt = ONE_CNT;
      PUSH_MEM_OP: begin
        need_cnt = '0;
        pushes = 1'b1;
      end
      default: begin
        need_cnt = '0;
        pushes = instr_reg[PUSH_ZERO_LSB] & ~slot_reg; // zero push flag on first slot
      end
    endcase
    deep_addr = top_ptr_reg - ADDR_W'(cached_count_reg) + PTR_STEP;
  end

  // arithmetic core fed by the two top cache entries
  stack_alu stack_alu_inst (
    .op_in(cur_op),
    .next_in(cache_reg[1]),
    .top_in(cache_reg[0]),
    .result_out(alu_result)
  );

  // sequencer and datapath next values
  always_comb begin
    state_next = state_reg;
    cache_next = cache_reg;
    cached_count_next = cached_count_reg;
    top_ptr_next = top_ptr_reg;
    frame_ptr_next = frame_ptr_reg;
    instr_next = instr_reg;
    slot_next = slot_reg;
    rd_next = 1'b0;
    wr_next = 1'b0;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    ready_next = 1'b0;
    if (frame_load_in) begin
      frame_ptr_next = frame_in;
    end
    case (state_reg)
      IDLE_ST: begin
        ready_next = 1'b1;
        if (instr_valid_in && ready_reg) begin
          instr_next = instr_in; // single fetch, two ops
          slot_next = 1'b0;
          ready_next = 1'b0;
          state_next = DECODE_ST;
        end
      end
      DECODE_ST: begin
        if (cached_count_reg < need_cnt) begin
          // missing operand: fetch below cached words
          rd_next = 1'b1;
          addr_next = top_ptr_reg - ADDR_W'(cached_count_reg);
          state_next = FILL_WAIT_ST;
        end else if (pushes && cached_count_reg == CNT_W'(CACHE_DEPTH)) begin
          // cache full: write deepest word home first
          wr_next = 1'b1;
          addr_next = deep_addr;
          wdata_next = cache_reg[CACHE_DEPTH-1];
          state_next = SPILL_ST;
        end else if (cur_op == PUSH_MEM_OP) begin
          // relative address from frame pointer
          rd_next = 1'b1;
          addr_next = frame_ptr_reg + ADDR_W'(instr_reg[REL_LSB +: REL_W]);
          state_next = PUSH_WAIT_ST;
        end else begin
          state_next = EXEC_ST;
        end
      end
      FILL_WAIT_ST: state_next = FILL_ST;
      FILL_ST: begin
        // fetched word becomes the deepest cached element
        cache_next[cached_count_reg[1:0]] = mem_rdata_in;
        cached_count_next = cached_count_reg + ONE_CNT;
        state_next = DECODE_ST;
      end
      SPILL_ST: begin
        cached_count_next = cached_count_reg - ONE_CNT;
        state_next = DECODE_ST;
      end
      PUSH_WAIT_ST: state_next = PUSH_RD_ST;
      PUSH_RD_ST: begin
        for (int i = CACHE_DEPTH-1; i > 0; i--) begin
          cache_next[i] = cache_reg[i-1];
        end
        cache_next[0] = mem_rdata_in;
        cached_count_next = cached_count_reg + ONE_CNT;
        top_ptr_next = top_ptr_reg + PTR_STEP;
        state_next = EXEC_ST;
      end
      EXEC_ST: begin
        case (cur_op)
          drop_top_op: begin
            // memory untouched, only pointer moves
            for (int i = 0; i < CACHE_DEPTH-1; i++) begin
              cache_next[i] = cache_reg[i+1];
            end
            cached_count_next = cached_count_reg - ONE_CNT;
            top_ptr_next = top_ptr_reg - PTR_STEP;
          end
          ADD_OP, product_op, SUB_OP, DIV_DROP_OP: begin
            // two operands replaced by one result
            cache_next[0] = alu_result;
            for (int i = 1; i < CACHE_DEPTH-1; i++) begin
              cache_next[i] = cache_reg[i+1];
            end
            cached_count_next = cached_count_reg - ONE_CNT;
            top_ptr_next = top_ptr_reg - PTR_STEP;
          end
          NEG_OP: cache_next[0] = alu_result;
          PUSH_MEM_OP: ; // already completed on read
          default: begin
            if (pushes) begin
              for (int i = CACHE_DEPTH-1; i > 0; i--) begin
                cache_next[i] = cache_reg[i-1];
              end
              cache_next[0] = ZERO_WORD;
              cached_count_next = cached_count_reg + ONE_CNT;
              top_ptr_next = top_ptr_reg + PTR_STEP;
            end
          end
        endcase
        if (!slot_reg) begin
          slot_next = 1'b1; // run packed second op
          state_next = DECODE_ST;
        end else begin
          state_next = IDLE_ST;
          ready_next = 1'b1;
        end
      end
      default: state_next = IDLE_ST;
    endcase
  end

  // register all state
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state_reg <= IDLE_ST;
      for (int i = 0; i < CACHE_DEPTH; i++) begin
        cache_reg[i] <= ZERO_WORD;
      end
      cached_count_reg <= '0;
      top_ptr_reg <= PTR_RESET;
      frame_ptr_reg <= PTR_RESET;
      instr_reg <= ZERO_WORD;
      slot_reg <= 1'b0;
      rd_reg <= 1'b0;
      wr_reg <= 1'b0;
      addr_reg <= PTR_RESET;
      wdata_reg <= ZERO_WORD;
      ready_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cache_reg <= cache_next;
      cached_count_reg <= cached_count_next;
      top_ptr_reg <= top_ptr_next;
      frame_ptr_reg <= frame_ptr_next;
      instr_reg <= instr_next;
      slot_reg <= slot_next;
      rd_reg <= rd_next;
      wr_reg <= wr_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      ready_reg <= ready_next;
    end
  end

  // outputs straight from flops
  assign instr_ready_out = ready_reg;
  assign mem_rd_out = rd_reg;
  assign mem_wr_out = wr_reg;
  assign mem_addr_out = addr_reg;
  assign mem_wdata_out = wdata_reg;
  assign top_ptr_out = top_ptr_reg;
  assign frame_ptr_out = frame_ptr_reg;
  assign cached_count_out = cached_count_reg;
  assign top_word_out = cache_reg[0];

  // drop moves pointer down by one
  AST_DROP_DEC: assert property (@(posedge mclk_in)
    disable iff (rst_in) (state_reg == EXEC_ST && cur_op == drop_top_op)
    |=> top_ptr_reg == $past(top_ptr_reg) - PTR_STEP)
    else $error("drop did not decrement top pointer");
  // drop leaves memory alone
  AST_DROP_NO_WR: assert property (@(posedge mclk_in)
    disable iff (rst_in) (state_reg == EXEC_ST && cur_op == drop_top_op)
    |=> !wr_reg)
    else $error("drop wrote memory");
  // add result lands on top
  AST_ADD_SUM: assert property (@(posedge mclk_in)
    disable iff (rst_in) (state_reg == EXEC_ST && cur_op == ADD_OP)
    |=> cache_reg[0] == WORD_W'($past(cache_reg[1]) + $past(cache_reg[0])))
    else $error("add result wrong");
  // product truncated to word
  AST_MUL_PROD: assert property (@(posedge mclk_in)
    disable iff (rst_in) (state_reg == EXEC_ST && cur_op == product_op)
    |=> cache_reg[0] == WORD_W'($past(cache_reg[1]) * $past(cache_reg[0])))
    else $error("product wrong");
  // subtract order next minus top
  AST_SUB_ORDER: assert property (@(posedge mclk_in)
    disable iff (rst_in) (state_reg == EXEC_ST && cur_op == SUB_OP)
    |=> cache_reg[0] == WORD_W'($past(cache_reg[1]) - $past(cache_reg[0])))
    else $error("subtract order wrong");
  // negate keeps depth
  AST_NEG_DEPTH: assert property (@(posedge mclk_in)
    disable iff (rst_in) (state_reg == EXEC_ST && cur_op == NEG_OP)
    |=> $stable(top_ptr_reg) && cache_reg[0] == WORD_W'(ZERO_WORD - $past(cache_reg[0])))
    else $error("negate wrong");
  // cache never exceeds four
  AST_CACHE_CAP: assert property (@(posedge mclk_in)
    disable iff (rst_in) cached_count_reg <= CNT_W'(CACHE_DEPTH))
    else $error("cache overflow");
  // two-operand op runs only with two cached
  AST_OPERANDS: assert property (@(posedge mclk_in)
    disable iff (rst_in) (state_reg == EXEC_ST && need_cnt == MIN_OPERANDS)
    |-> cached_count_reg >= MIN_OPERANDS)
    else $error("operand missing at execute");
  // each fill adds exactly one cached word
  AST_FILL_ONE: assert property (@(posedge mclk_in)
    disable iff (rst_in) (state_reg == FILL_ST)
    |=> cached_count_reg == $past(cached_count_reg) + ONE_CNT)
    else $error("fill count wrong");
  // memory push bumps pointer
  AST_PUSH_INC: assert property (@(posedge mclk_in)
    disable iff (rst_in) (state_reg == PUSH_RD_ST)
    |=> top_ptr_reg == $past(top_ptr_reg) + PTR_STEP && cache_reg[0] == $past(mem_rdata_in))
    else $error("push from memory wrong");
  // divide drops one element, top pointer down by one
  AST_DIV_DROP: assert property (@(posedge mclk_in)
    disable iff (rst_in) (state_reg == EXEC_ST && cur_op == DIV_DROP_OP)
    |=> top_ptr_reg == $past(top_ptr_reg) - PTR_STEP)
    else $error("divide did not drop remainder");
  // zero push leaves a zero word on top
  AST_ZERO_PUSH: assert property (@(posedge mclk_in)
    disable iff (rst_in) (state_reg == EXEC_ST && cur_op == NOP_OP && pushes)
    |=> cache_reg[0] == ZERO_WORD && top_ptr_reg == $past(top_ptr_reg) + PTR_STEP)
    else $error("zero push wrong");
  // spill writes the deepest cached word
  AST_SPILL_DATA: assert property (@(posedge mclk_in)
    disable iff (rst_in) (state_reg == SPILL_ST)
    |-> wr_reg && wdata_reg == cache_reg[CACHE_DEPTH-1])
    else $error("spill data wrong");
endmodule // stack_arithmetic_unit
`default_nettype wire

/* File: test/stack_memory.sv */
// word memory standing in for main memory behind the datapath
// assumes registered one-cycle read and write strobes from the datapath
`timescale 1ns/10ps
`default_nettype none
module stack_memory
  import stack_arith_pkg::*;
(
  // clock
  input wire logic mclk_in,
  // request
  input wire logic rd_in,
  input wire logic wr_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [WORD_W-1:0] wdata_in,
  // answer
  output logic [WORD_W-1:0] rdata_out
);
  logic [WORD_W-1:0] mem [0:65535]; // whole address space
  int hold = 0; // cycles read data still stands
  logic [WORD_W-1:0] rdata_reg = 16'h0000; // registered read data
  assign rdata_out = rdata_reg;
  // preload a pattern the bench can recompute
  initial begin
    for (int a = 0; a < 65536; a++) begin
      mem[a] = {8'(a), 8'(a >> 8)} ^ 16'h3C5A;
    end
  end
  // read data stands two cycles, then scrambles so stale data never passes
  always @(posedge mclk_in) begin
    if (wr_in) begin
      mem[addr_in] <= wdata_in;
    end
    if (rd_in) begin
      rdata_reg <= mem[addr_in];
      hold <= 1;
    end else if (hold > 0) begin
      hold <= hold - 1;
    end else begin
      rdata_reg <= ~rdata_reg;
    end
  end
endmodule // stack_memory
`default_nettype wire

/* File: test/stack_arithmetic_unit_bench.sv */
// self-checking bench for the stack datapath against a memory model
// assumes the package and stack_memory are compiled first
`timescale 1ns/10ps
`default_nettype none
module stack_arithmetic_unit_bench;
  import stack_arith_pkg::*;
  localparam logic [ADDR_W-1:0] FRAME_BASE = 16'h8000; // far from the stack
  logic mclk_in = 1'b0; // clock
  logic rst_in = 1'b1; // reset
  logic instr_valid_in = 1'b0; // word offered
  logic frame_load_in = 1'b0; // frame load
  logic [WORD_W-1:0] instr_in = 16'h0000;
  logic [ADDR_W-1:0] frame_in = 16'h0000;
  logic instr_ready_out, mem_rd_out, mem_wr_out;
  logic [ADDR_W-1:0] mem_addr_out, top_ptr_out, frame_ptr_out;
  logic [WORD_W-1:0] mem_wdata_out, mem_rdata_in, top_word_out;
  logic [CNT_W-1:0] cached_count_out;
  logic [WORD_W-1:0] exp_mem [0:65535]; // expected stack image
  logic [ADDR_W-1:0] exp_tp = 16'h0000; // expected top pointer
  int n_fail = 0;
  int comparisons = 0;
  int n_rd = 0; // reads since start
  int n_wr = 0; // writes since start
  int rd_base = 0; // reads before current word
  int wr_base = 0; // writes before current word
  logic [ADDR_W-1:0] wr_addr_seen = 16'h0000; // last write address
  logic [WORD_W-1:0] wr_data_seen = 16'h0000; // last write data
  always #5 mclk_in = ~mclk_in;
  // strobe counters and last write capture
  always @(posedge mclk_in) begin
    n_rd <= n_rd + int'(mem_rd_out === 1'b1);
    n_wr <= n_wr + int'(mem_wr_out === 1'b1);
    if (mem_wr_out === 1'b1) begin
      wr_addr_seen <= mem_addr_out;
      wr_data_seen <= mem_wdata_out;
    end
  end
  stack_arithmetic_unit stack_arithmetic_unit_inst (.mclk_in(mclk_in), .rst_in(rst_in),
    .instr_valid_in(instr_valid_in), .instr_in(instr_in), .instr_ready_out(instr_ready_out),
    .frame_load_in(frame_load_in), .frame_in(frame_in), .mem_rd_out(mem_rd_out),
    .mem_wr_out(mem_wr_out), .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out),
    .mem_rdata_in(mem_rdata_in), .top_ptr_out(top_ptr_out), .frame_ptr_out(frame_ptr_out),
    .cached_count_out(cached_count_out), .top_word_out(top_word_out));
  stack_memory stack_memory_inst (.mclk_in(mclk_in), .rd_in(mem_rd_out), .wr_in(mem_wr_out),
    .addr_in(mem_addr_out), .wdata_in(mem_wdata_out), .rdata_out(mem_rdata_in));
  // verdict and end of run
  task automatic wrap_up;
    $display("counts: comparisons=%0d mismatches=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // word compare
  task automatic check_word(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // count compare
  task automatic check_cnt(input logic [CNT_W-1:0] got, input logic [CNT_W-1:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // memory preload pattern, same as the model's
  function automatic logic [WORD_W-1:0] init_word(input logic [ADDR_W-1:0] a);
    return {a[7:0], a[15:8]} ^ 16'h3C5A;
  endfunction
  // pack one instruction word
  function automatic logic [WORD_W-1:0] mk(input logic pz, input logic [2:0] s,
    input logic [2:0] f, input logic [7:0] rel);
    return {1'b0, pz, s, f, rel};
  endfunction
  // expected effect of one stack operation
  task automatic apply_op(input logic [2:0] op, input logic [7:0] rel, input logic pz);
    logic [WORD_W-1:0] a;
    logic [WORD_W-1:0] b;
    logic [ADDR_W-1:0] dn;
    dn = exp_tp - PTR_STEP;
    a = exp_mem[dn];
    b = exp_mem[exp_tp];
    case (op)
      3'h0: if (pz) begin
        exp_tp = exp_tp + PTR_STEP;
        exp_mem[exp_tp] = ZERO_WORD;
      end
      3'h1: exp_tp = dn;
      3'h2: begin
        exp_tp = exp_tp + PTR_STEP;
        exp_mem[exp_tp] = exp_mem[FRAME_BASE + {8'h00, rel}];
      end
      3'h3: exp_mem[dn] = a + b;
      3'h4: exp_mem[dn] = a * b;
      3'h5: exp_mem[dn] = a - b;
      3'h6: exp_mem[exp_tp] = -b;
      default: begin
        // signed quotient, zero for a zero divisor
        if (b == ZERO_WORD) begin
          exp_mem[dn] = ZERO_WORD;
        end else begin
          exp_mem[dn] = 16'($signed(a) / $signed(b));
        end
      end
    endcase
    if (op inside {3'h3, 3'h4, 3'h5, 3'h7}) begin
      exp_tp = dn;
    end
  endtask
  // bounded wait for ready, sampled mid-cycle
  task automatic wait_ready;
    int k;
    k = 0;
    @(negedge mclk_in);
    while (instr_ready_out !== 1'b1) begin
      k++;
      if (k > 300) begin
        n_fail++;
        wrap_up();
      end
      @(negedge mclk_in);
    end
  endtask
  // issue one packed word and check the stack afterwards
  task automatic do_word(input logic [WORD_W-1:0] w);
    logic [2:0] last;
    wait_ready();
    rd_base = n_rd;
    wr_base = n_wr;
    apply_op(w[10:8], w[7:0], w[14]);
    apply_op(w[13:11], w[7:0], 1'b0);
    @(posedge mclk_in);
    instr_valid_in <= 1'b1;
    instr_in <= w;
    @(posedge mclk_in);
    instr_valid_in <= 1'b0;
    wait_ready();
    last = (w[13:11] != 3'h0) ? w[13:11] : w[10:8];
    check_word(top_ptr_out, exp_tp);
    if (last > 3'h1 || w[14:8] == 7'h40) begin
      check_word(top_word_out, exp_mem[exp_tp]);
    end
    if (n_wr != wr_base) begin
      check_word(wr_data_seen, exp_mem[wr_addr_seen]);
    end
    check_cnt(cached_count_out <= 3'h4 ? 3'h0 : cached_count_out, 3'h0);
  endtask
  // main sequence
  initial begin
    for (int a = 0; a < 65536; a++) begin
      exp_mem[a] = init_word(16'(a));
    end
    void'($urandom(16));
    repeat (16) @(posedge mclk_in);
    rst_in <= 1'b0;
    @(negedge mclk_in);
    check_word(top_ptr_out, PTR_RESET);
    check_cnt(cached_count_out, 3'h0);
    @(posedge mclk_in);
    frame_load_in <= 1'b1;
    frame_in <= FRAME_BASE;
    @(posedge mclk_in);
    frame_load_in <= 1'b0;
    @(negedge mclk_in);
    check_word(frame_ptr_out, FRAME_BASE);
    $display("test reset done");
    do_word(mk(1'b0, NOP_OP, ADD_OP, 8'h00));
    check_cnt(3'(n_rd - rd_base), MIN_OPERANDS);
    do_word(mk(1'b0, PUSH_MEM_OP, PUSH_MEM_OP, 8'h05));
    do_word(mk(1'b0, PUSH_MEM_OP, PUSH_MEM_OP, 8'hFF));
    do_word(mk(1'b0, PUSH_MEM_OP, PUSH_MEM_OP, 8'h80));
    check_cnt(3'(n_wr - wr_base), 3'h2);
    check_cnt(cached_count_out, 3'h4);
    do_word(mk(1'b1, DIV_DROP_OP, NOP_OP, 8'h00));
    do_word(mk(1'b0, NEG_OP, SUB_OP, 8'h00));
    do_word(mk(1'b0, ADD_OP, product_op, 8'h00));
    do_word(mk(1'b0, DIV_DROP_OP, PUSH_MEM_OP, 8'h10));
    do_word(mk(1'b0, drop_top_op, drop_top_op, 8'h00));
    check_cnt(3'(n_wr - wr_base), 3'h0);
    $display("test corner done");
    repeat (300) begin
      do_word(mk(1'($urandom_range(1)), 3'($urandom_range(7)), 3'($urandom_range(7)),
        8'($urandom)));
    end
    $display("test random done");
    wrap_up();
  end
endmodule // stack_arithmetic_unit_bench
`default_nettype wire
